// [verilog/vdtc_pkg.sv]
// Package with constants and types for the vectored data transfer controller.
package vdtc_pkg;
  // Descriptor layout: four 32-bit words in memory.
  localparam int unsigned DESC_WORDS = 4;
  localparam logic [31:0] DESC_STRIDE = 32'h0000_0004;
  localparam logic [31:0] VEC_STRIDE  = 32'h0000_0004;
  // Word 0 field positions (mode word), then word 3 count and block fields.
  localparam int unsigned F_SIZE_LO  = 0;
  localparam int unsigned F_SIZE_HI  = 1;
  localparam int unsigned F_MODE_LO  = 2;
  localparam int unsigned F_MODE_HI  = 3;
  localparam int unsigned F_SRC_LO   = 4;
  localparam int unsigned F_SRC_HI   = 5;
  localparam int unsigned F_DST_LO   = 6;
  localparam int unsigned F_DST_HI   = 7;
  localparam int unsigned F_RPT_DST  = 8;
  localparam int unsigned F_IRQ_EACH = 9;
  localparam int unsigned F_CHN_LO   = 10;
  localparam int unsigned F_CHN_HI   = 11;
  localparam int unsigned F_RLEN_LO  = 16;
  localparam int unsigned F_RLEN_HI  = 23;
  localparam int unsigned F_CNT_LO   = 0;
  localparam int unsigned F_CNT_HI   = 15;
  localparam int unsigned F_BLK_LO   = 16;
  localparam int unsigned F_BLK_HI   = 31;
  localparam logic [15:0] CNT_ONE    = 16'h0001;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [8:0]  RLEN_ONE   = 9'h001;
  localparam logic [31:0] UNIT_1     = 32'h0000_0001;
  localparam logic [31:0] UNIT_2     = 32'h0000_0002;
  localparam logic [31:0] UNIT_4     = 32'h0000_0004;
  localparam logic [1:0]  IDX_MODE = 2'h0;
  localparam logic [1:0]  IDX_SRC  = 2'h1;
  localparam logic [1:0]  IDX_DST  = 2'h2;
  localparam logic [1:0]  IDX_CNT  = 2'h3;
  localparam logic [1:0]  IDX_LAST = 2'h3;

  typedef enum logic [1:0] {
    SZ_BYTE = 2'b00, SZ_HALF = 2'b01, SZ_WORD = 2'b10, SZ_RSVD = 2'b11
  } vdtc_size_t;
  typedef enum logic [1:0] {
    MD_NORMAL = 2'b00, MD_REPEAT = 2'b01, MD_BLOCK = 2'b10, MD_RSVD = 2'b11
  } vdtc_mode_t;
  typedef enum logic [1:0] {
    AM_FIXED = 2'b00, AM_INC = 2'b01, AM_DEC = 2'b10, AM_RSVD = 2'b11
  } vdtc_addr_t;
  typedef enum logic [1:0] {
    CH_NONE = 2'b00, CH_EACH = 2'b01, CH_END = 2'b10, CH_RSVD = 2'b11
  } vdtc_chain_t;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000, ST_VEC   = 4'b0001, ST_DESC  = 4'b0010,
    ST_RD    = 4'b0011, ST_WR    = 4'b0100, ST_WB    = 4'b0101,
    ST_NEXT  = 4'b0110, ST_DONE  = 4'b0111
  } vdtc_state_t;
endpackage : vdtc_pkg

// [verilog/vdtc_top.sv]
// Vectored data transfer controller: vector fetch, descriptor, move, write-back.
// Behaviour
// RULE1: Each interrupt vector owns one RAM slot pointing at its descriptor.
// RULE2: Activation reads vector slot, then descriptor, then moves data.
// RULE3: Updated descriptor words are written back to where the slot points.
// RULE4: Data unit is one, two or four bytes in every mode.
// RULE5: Normal mode moves one unit per activation, counts down, stops at zero.
// RULE6: Source and destination each stay fixed, increment or decrement by unit.
// RULE7: Repeat mode length is one to 256 units.
// RULE8: Repeat end reloads length, rewinds repeat address, keeps running.
// RULE9: Block mode moves one to 256 units per activation; 16-bit block count.
// RULE10: After each block repeat address rewinds, other address moves on.
// RULE11: Software aligns both addresses to the unit size.
// RULE12: Normal length zero means 65536 transfers.
// RULE13: Block count zero means 65536 blocks.
// RULE14: Every descriptor but the last in a chain carries a chain setting.
// RULE15: Per-transfer chaining runs the next descriptor after every transfer.
// RULE16: End-only chaining runs the next descriptor after the final transfer.
// RULE17: Completion is raised on the activating source's own interrupt line.
// RULE18: Normal mode interrupts per transfer, or only after the final one.
// RULE19: Repeat mode interrupts per transfer, or after each completed repeat.
// RULE20: Block mode interrupts per block, or only after the final block.
// RULE21: Vector table holds four bytes per interrupt source.
// RULE22: Software starts transfers only through the event link software event.
// RULE23: Write-back finishes before another activation is serviced.
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module vdtc_top
  import vdtc_pkg::*;
#(
  parameter int unsigned irq_source_count = 8,
  parameter int unsigned IW = $clog2(irq_source_count)
) (
  // Clock and reset.
  input  wire logic                        clk,
  input  wire logic                        reset,
  // Control.
  input  wire logic [31:0]                 vecBase,
  input  wire logic [irq_source_count-1:0] actReq,
  // Interrupt path to the CPU and to the sources.
  output logic [irq_source_count-1:0]      cpuIrq,
  output logic [irq_source_count-1:0]      actDone,
  output logic [irq_source_count-1:0]      actDisable,
  output logic                             busy,
  // Memory bus.
  output logic                             memReq,
  output logic                             memWe,
  output logic [31:0]                      memAddr,
  output logic [31:0]                      memWdata,
  output logic [1:0]                       memSize,
  input  wire logic                        memAck,
  input  wire logic [31:0]                 memRdata
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  vdtc_state_t state_q, state_d;
  logic [31:0] desc_q [DESC_WORDS];
  logic [31:0] descPtr_q, dataBuf_q, rptStart_q;
  logic [1:0]  wIdx_q;
  logic [IW-1:0] src_q;
  logic [8:0]  blkLeft_q;
  logic        irqHit_q, chainGo_q, lastTr_q;
  logic [irq_source_count-1:0] dis_q;

  // ----------------------------------------------------------------------
  // Descriptor decode
  // ----------------------------------------------------------------------
  vdtc_size_t  uSize;
  vdtc_mode_t  uMode;
  vdtc_addr_t  sMode, dMode;
  vdtc_chain_t cMode;
  wire logic [31:0] w0 = desc_q[IDX_MODE];
  assign uSize = vdtc_size_t'(w0[F_SIZE_HI:F_SIZE_LO]);
  assign uMode = vdtc_mode_t'(w0[F_MODE_HI:F_MODE_LO]);
  assign sMode = vdtc_addr_t'(w0[F_SRC_HI:F_SRC_LO]);
  assign dMode = vdtc_addr_t'(w0[F_DST_HI:F_DST_LO]);
  assign cMode = vdtc_chain_t'(w0[F_CHN_HI:F_CHN_LO]);
  wire logic       rptDst  = w0[F_RPT_DST];
  wire logic       irqEach = w0[F_IRQ_EACH];
  // Repeat length field of zero encodes 256 units.
  // RULE7: repeat length range
  wire logic [8:0] rLen = {w0[F_RLEN_HI:F_RLEN_LO] == 8'h00,
                           w0[F_RLEN_HI:F_RLEN_LO]};
  wire logic [15:0] cnt = desc_q[IDX_CNT][F_CNT_HI:F_CNT_LO];
  wire logic [15:0] blk = desc_q[IDX_CNT][F_BLK_HI:F_BLK_LO];

  // Unit size in bytes.
  // RULE4: unit size select
  wire logic [31:0] unitB = (uSize == SZ_WORD) ? UNIT_4 :
                            (uSize == SZ_HALF) ? UNIT_2 : UNIT_1;

  // Address stepping per unit.
  // RULE6: address update modes
  function automatic logic [31:0] stepA(input logic [31:0] a,
                                        input vdtc_addr_t m,
                                        input logic [31:0] u);
    logic [31:0] r;
    r = a;
    if (m == AM_INC) begin
      r = a + u;
    end else if (m == AM_DEC) begin
      r = a - u;
    end
    return r;
  endfunction : stepA

  wire logic [31:0] srcStep = stepA(desc_q[IDX_SRC], sMode, unitB);
  wire logic [31:0] dstStep = stepA(desc_q[IDX_DST], dMode, unitB);

  // Repeat span in bytes; rewinding undoes a whole repeat of stepping.
  wire logic [31:0] span = 32'(rLen) * unitB;
  function automatic logic [31:0] backA(input logic [31:0] a,
                                        input vdtc_addr_t m,
                                        input logic [31:0] s);
    logic [31:0] r;
    r = a;
    if (m == AM_INC) begin
      r = a - s;
    end else if (m == AM_DEC) begin
      r = a + s;
    end
    return r;
  endfunction : backA
  // Counter decrement; zero wraps to 65535, so zero acts as 65536.
  // RULE12: zero as 65536
  wire logic [15:0] cntDec = cnt - CNT_ONE;
  // RULE13: zero block count
  wire logic [15:0] blkDec = blk - CNT_ONE;
  wire logic        cntEnd = (cnt == CNT_ONE);
  wire logic        blkEnd = (blk == CNT_ONE);
  wire logic        unitLast = (blkLeft_q == RLEN_ONE);

  // Pending activation pick: lowest index not disabled.
  logic          anyReq;
  logic [IW-1:0] pick;
  always_comb begin
    anyReq = 1'b0;
    pick   = '0;
    for (int i = irq_source_count - 1; i >= 0; i--) begin
      // A request still standing while its done pulse shows is not taken.
      if (actReq[i] && !dis_q[i] && !actDone[i]) begin
        anyReq = 1'b1;
        pick   = IW'(i);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  wire logic wbLast = (wIdx_q == IDX_LAST);
  // RULE2: vector, descriptor, data order
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (anyReq) begin
        state_d = ST_VEC;
      end
      ST_VEC:  if (memAck) begin
        state_d = ST_DESC;
      end
      ST_DESC: if (memAck && wbLast) begin
        state_d = ST_RD;
      end
      ST_RD:   if (memAck) begin
        state_d = ST_WR;
      end
      ST_WR:   if (memAck) begin
        state_d = (uMode == MD_BLOCK && !unitLast) ? ST_RD : ST_WB;
      end
      // RULE23: write-back before next activation
      ST_WB:   if (memAck && wbLast) begin
        state_d = chainGo_q ? ST_NEXT : ST_DONE;
      end
      ST_NEXT: state_d = ST_DESC;
      ST_DONE: state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  // Bus address and data selection.
  wire logic rdPhase = (state_q == ST_VEC) || (state_q == ST_DESC) ||
                       (state_q == ST_RD);
  wire logic wrPhase = (state_q == ST_WR) || (state_q == ST_WB);
  // Next word index and pointer, so that the bus sees the coming access.
  wire logic [1:0] wIdxN =
    ((state_q == ST_DESC || state_q == ST_WB) && memAck) ? wIdx_q + 2'h1 :
    (state_q == ST_VEC || state_q == ST_WR || state_q == ST_NEXT) ?
    IDX_MODE : wIdx_q;
  wire logic [31:0] descPtrN =
    (state_q == ST_VEC && memAck) ? memRdata :
    (state_q == ST_NEXT) ? descPtr_q + (DESC_STRIDE << 2) : descPtr_q;
  wire logic [IW-1:0] srcN = (state_q == ST_IDLE) ? pick : src_q;
  wire logic [31:0] wordOff = {28'h000_0000, wIdxN, 2'b00};

  // Transfer bookkeeping at the end of each write.
  logic [31:0] nSrc, nDst, nCnt;
  logic        nLast, nIrq;
  always_comb begin
    nSrc  = srcStep;
    nDst  = dstStep;
    nCnt  = desc_q[IDX_CNT];
    nLast = 1'b0;
    nIrq  = 1'b0;
    unique case (uMode)
      // RULE5: one unit, count down
      MD_NORMAL: begin
        nCnt[F_CNT_HI:F_CNT_LO] = cntDec;
        nLast = cntEnd;
        // RULE18: normal mode interrupt
        nIrq  = irqEach || cntEnd;
      end
      // RULE8: repeat reload and rewind
      MD_REPEAT: begin
        nCnt[F_CNT_HI:F_CNT_LO] = cntEnd ? {7'h00, rLen} : cntDec;
        if (cntEnd && rptDst) begin
          nDst = backA(dstStep, dMode, span);
        end else if (cntEnd) begin
          nSrc = backA(srcStep, sMode, span);
        end
        nLast = cntEnd;
        // RULE19: repeat mode interrupt
        nIrq  = irqEach || cntEnd;
      end
      default: begin
        // RULE10: block rewind and advance
        if (unitLast && rptDst) begin
          nDst = rptStart_q;
        end else if (unitLast) begin
          nSrc = rptStart_q;
        end
        // RULE9: block count field
        if (unitLast) begin
          nCnt[F_BLK_HI:F_BLK_LO] = blkDec;
        end
        nLast = unitLast && blkEnd;
        // RULE20: block mode interrupt
        nIrq  = unitLast && (irqEach || blkEnd);
      end
    endcase
  end

  // Address of the access that the coming state makes.
  // RULE21: four bytes per source
  wire logic [31:0] vecAddr = vecBase + 32'({srcN, 2'b00});
  wire logic [31:0] nextAddr =
    (state_d == ST_VEC) ? vecAddr :
    (state_d == ST_RD)  ? ((state_q == ST_WR) ? nSrc : desc_q[IDX_SRC]) :
    (state_d == ST_WR)  ? desc_q[IDX_DST] : descPtrN + wordOff;

  // RULE14: chain stops at first descriptor without setting
  // RULE15: per-transfer chaining
  // RULE16: end-only chaining
  wire logic chainNow = (cMode == CH_EACH) || (cMode == CH_END && nLast);
  wire logic wbIrqNow = (uMode == MD_REPEAT) ? nIrq : (nIrq || nLast);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Descriptor storage and pointers.
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < DESC_WORDS; k++) begin
        desc_q[k] <= 32'h0000_0000;
      end
      descPtr_q <= 32'h0000_0000;
      dataBuf_q <= 32'h0000_0000;
      rptStart_q <= 32'h0000_0000;
      wIdx_q <= IDX_MODE;
      src_q <= '0;
      blkLeft_q <= RLEN_ONE;
      irqHit_q <= 1'b0;
      chainGo_q <= 1'b0;
      lastTr_q <= 1'b0;
    end else begin
      if (state_q == ST_IDLE && anyReq) begin
        src_q    <= pick;
        irqHit_q <= 1'b0;
      end
      // RULE1: slot gives descriptor pointer
      if (state_q == ST_VEC && memAck) begin
        descPtr_q <= memRdata;
        wIdx_q    <= IDX_MODE;
      end
      if (state_q == ST_DESC && memAck) begin
        desc_q[wIdx_q] <= memRdata;
        wIdx_q         <= wIdx_q + 2'h1;
      end
      // Repeat-side start address and block unit counter latched on load.
      if (state_q == ST_DESC && memAck && wbLast) begin
        rptStart_q <= desc_q[IDX_MODE][F_RPT_DST] ? desc_q[IDX_DST]
                                                  : desc_q[IDX_SRC];
        blkLeft_q  <= rLen;
      end
      if (state_q == ST_RD && memAck) begin
        dataBuf_q <= memRdata;
      end
      if (state_q == ST_WR && memAck) begin
        desc_q[IDX_SRC] <= nSrc;
        desc_q[IDX_DST] <= nDst;
        desc_q[IDX_CNT] <= nCnt;
        blkLeft_q <= blkLeft_q - RLEN_ONE;
        if (uMode != MD_BLOCK || unitLast) begin
          irqHit_q  <= irqHit_q || wbIrqNow;
          chainGo_q <= chainNow;
          lastTr_q  <= nLast;
          wIdx_q    <= IDX_MODE;
        end
      end
      // RULE3: write-back to descriptor location
      if (state_q == ST_WB && memAck) begin
        wIdx_q <= wIdx_q + 2'h1;
      end
      if (state_q == ST_NEXT) begin
        descPtr_q <= descPtr_q + (DESC_STRIDE << 2);
        wIdx_q    <= IDX_MODE;
      end
    end
  end

  // Bus outputs registered from the next state.
  wire logic nRd = (state_d == ST_VEC) || (state_d == ST_DESC) ||
                   (state_d == ST_RD);
  wire logic nWr = (state_d == ST_WR) || (state_d == ST_WB);
  always_ff @(posedge clk) begin
    if (reset) begin
      memReq   <= 1'b0;
      memWe    <= 1'b0;
      memAddr  <= 32'h0000_0000;
      memWdata <= 32'h0000_0000;
      memSize  <= SZ_WORD;
      busy     <= 1'b0;
    end else begin
      memReq   <= (nRd || nWr) && !(memReq && memAck && (rdPhase || wrPhase)
                  && state_d == state_q && state_q != ST_DESC
                  && state_q != ST_WB);
      memWe    <= nWr;
      memAddr  <= nextAddr;
      memWdata <= (state_d != ST_WR) ? desc_q[wIdxN] :
                  (state_q == ST_RD) ? memRdata : dataBuf_q;
      memSize  <= (state_d == ST_RD || state_d == ST_WR) ? uSize : SZ_WORD;
      busy     <= (state_d != ST_IDLE);
    end
  end

  // Bus requests hold steady until accepted.
  a_req_hold: assert property ( // RULE2
    @(posedge clk) disable iff (reset) memReq && !memAck |=> memReq)
    else $error("memory request dropped before acknowledge");
  a_addr_hold: assert property ( // RULE2
    @(posedge clk) disable iff (reset) memReq && !memAck |=> $stable(memAddr))
    else $error("memory address moved before acknowledge");
  a_vec_first: assert property ( // RULE2
    @(posedge clk) disable iff (reset) $rose(busy) |-> memReq && !memWe)
    else $error("activation did not open with a read");
  a_idle_quiet: assert property ( // RULE23
    @(posedge clk) disable iff (reset) !busy |-> !memReq)
    else $error("memory request while idle");
  a_wb_write: assert property ( // RULE3
    @(posedge clk) disable iff (reset) state_q == ST_WB && memReq |-> memWe)
    else $error("write-back access is not a write");
  a_size_legal: assert property ( // RULE4
    @(posedge clk) disable iff (reset) memReq |-> memSize != SZ_RSVD)
    else $error("reserved unit size on the bus");
  a_irq_done: assert property ( // RULE17
    @(posedge clk) disable iff (reset) (cpuIrq & ~actDone) == '0)
    else $error("interrupt without its done pulse");
  a_dis_sticky: assert property ( // RULE5
    @(posedge clk) disable iff (reset) 1'b1 |=>
    ($past(actDisable) & ~actDisable) == '0)
    else $error("source disable released");

  // Per-source interrupt, done pulse and disable latch.
  // RULE17: completion on source interrupt
  genvar g;
  generate
    for (g = 0; g < irq_source_count; g++) begin : gSrc
      wire logic fin = (state_q == ST_DONE) && (src_q == IW'(g));
      always_ff @(posedge clk) begin
        if (reset) begin
          cpuIrq[g]     <= 1'b0;
          actDone[g]    <= 1'b0;
          dis_q[g]      <= 1'b0;
          actDisable[g] <= 1'b0;
        end else begin
          cpuIrq[g]     <= fin && irqHit_q;
          actDone[g]    <= fin;
          dis_q[g]      <= dis_q[g] || (fin && lastTr_q &&
                           uMode != MD_REPEAT);
          actDisable[g] <= dis_q[g] || (fin && lastTr_q &&
                           uMode != MD_REPEAT);
        end
      end
    end
  endgenerate
endmodule : vdtc_top
`default_nettype wire

// [tb/vdtc_mem_model.sv]
// Memory model that answers the transfer engine's bus accesses.
`timescale 1ns/100ps
`default_nettype none
module vdtc_mem_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // Wait cycles before each acknowledge.
  input  wire logic [1:0]  lat,
  // Memory bus.
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  memSize,
  output logic             memAck,
  output logic [31:0]      memRdata
);
  logic [7:0] mem [0:1023];
  logic [1:0] waitQ;
  int         n;
  // Accepts one access after lat idle cycles; data toggles when not valid.
  always @(posedge clk) begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    n = 1 << memSize;
    if (reset) begin
      waitQ <= 2'h0;
      memRdata <= 32'h5a5a_a5a5;
    end else if (memReq && !memAck) begin
      if (waitQ == lat) begin
        waitQ <= 2'h0;
        memAck <= 1'b1;
        for (int k = 0; k < 4; k++) begin
          if (memWe && k < n) begin
            mem[memAddr[9:0] + 10'(k)] <= memWdata[8*k+:8];
          end
          memRdata[8*k+:8] <= (k < n) ? mem[memAddr[9:0] + 10'(k)] : 8'h00;
        end
      end else begin
        waitQ <= waitQ + 2'h1;
      end
    end
  end
endmodule : vdtc_mem_model
`default_nettype wire

// [tb/vdtc_top_tb.sv]
// Self-checking testbench for the vectored data transfer controller.
`timescale 1ns/100ps
`default_nettype none
module vdtc_top_tb;
  import vdtc_pkg::*;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic [31:0] vecBase = 32'h0000_0100;
  logic [7:0]  actReq = 8'h00;
  logic [1:0]  lat = 2'h0;
  logic [7:0]  cpuIrq, actDone, actDisable;
  logic        busy, memReq, memWe, memAck;
  logic [31:0] memAddr, memWdata, memRdata;
  logic [1:0]  memSize;
  logic [7:0]  irqSeen = 8'h00;
  int          miscompares = 0;
  int          num_checks = 0;

  vdtc_top vdtc_top_i (.clk(clk), .reset(reset), .vecBase(vecBase),
    .actReq(actReq), .cpuIrq(cpuIrq), .actDone(actDone),
    .actDisable(actDisable), .busy(busy), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize),
    .memAck(memAck), .memRdata(memRdata));
  vdtc_mem_model vdtc_mem_model_i (.clk(clk), .reset(reset), .lat(lat),
    .memReq(memReq), .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memSize(memSize), .memAck(memAck), .memRdata(memRdata));

  // Clock at 100 MHz and a sticky record of interrupt pulses.
  always #5 clk = ~clk;
  always @(posedge clk) irqSeen <= irqSeen | cpuIrq;

  // Compares of values and of single flags.
  task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : chk1

  // Memory image access for setup and result reading.
  function automatic logic [31:0] rd(input logic [31:0] a, input int n);
    rd = 32'h0000_0000;
    for (int k = 0; k < n; k++) rd[8*k+:8] = vdtc_mem_model_i.mem[a[9:0]+k];
  endfunction : rd
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++) vdtc_mem_model_i.mem[a[9:0]+k] = d[8*k+:8];
  endtask : wr
  task automatic desc(input logic [31:0] p, w0, s, d, c);
    wr(p, w0);
    wr(p + 32'h0000_0004, s);
    wr(p + 32'h0000_0008, d);
    wr(p + 32'h0000_000c, c);
  endtask : desc

  // Raises one source's request and holds it until serviced or refused.
  task automatic act(input int s, input logic expDone);
    int t;
    t = 0;
    irqSeen <= 8'h00;
    actReq[s] <= 1'b1;
    @(posedge clk);
    while (actDone[s] !== 1'b1 && t < 400) begin
      @(posedge clk);
      t++;
    end
    actReq[s] <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    chk1("actDone", expDone, actDone[s] === 1'b0 && t < 400);
  endtask : act

  // Ends the run with the verdict.
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    for (int i = 0; i < 1024; i++) vdtc_mem_model_i.mem[i] = 8'h00;
    // one pointer of four bytes per source
    for (int i = 0; i < 5; i++) wr(32'h0000_0100 + 4 * i, 32'h0000_0200 + 32 * i);
    // aligned addresses, chain set only on the descriptor at 0x280
    desc(32'h0000_0200, 32'h0000_0052, 32'h0000_0000, 32'h0000_0040, 32'h0000_0002);
    desc(32'h0000_0220, 32'h0000_0280, 32'h0000_0010, 32'h0000_005f, 32'h0000_0000);
    desc(32'h0000_0240, 32'h0002_0155, 32'h0000_0080, 32'h0000_00c0, 32'h0000_0002);
    desc(32'h0000_0260, 32'h0002_015a, 32'h0000_00a0, 32'h0000_00e0, 32'h0001_0002);
    desc(32'h0000_0280, 32'h0000_0852, 32'h0000_0000, 32'h0000_00f0, 32'h0000_0001);
    desc(32'h0000_0290, 32'h0000_0052, 32'h0000_0004, 32'h0000_00f4, 32'h0000_0001);
    wr(32'h0000_0000, 32'h1111_2222);
    wr(32'h0000_0004, 32'h3333_4444);
    wr(32'h0000_0010, 32'h0000_00a5);
    wr(32'h0000_0080, 32'h cafe_beef);
    wr(32'h0000_00a0, 32'h5555_0001);
    wr(32'h0000_00a4, 32'h5555_0002);
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // transfers start only from a source request
    act(0, 1'b1);
    chk("dst0", 32'h1111_2222, rd(32'h0000_0040, 4));
    chk("wbsrc0", 32'h0000_0004, rd(32'h0000_0204, 4));
    chk("wbdst0", 32'h0000_0044, rd(32'h0000_0208, 4));
    chk("wbcnt0", 32'h0000_0001, rd(32'h0000_020c, 4));
    chk1("irq0", 1'b0, irqSeen[0]);
    chk1("dis0", 1'b0, actDisable[0]);
    act(0, 1'b1);
    chk("dst0b", 32'h3333_4444, rd(32'h0000_0044, 4));
    chk("wbcnt0b", 32'h0000_0000, rd(32'h0000_020c, 4));
    chk1("irq0b", 1'b1, irqSeen[0]);
    chk1("dis0b", 1'b1, actDisable[0]);
    act(0, 1'b0);
    $display("normal mode test done");
    lat <= 2'h2;
    act(1, 1'b1);
    chk("dst1", 32'h0000_a500, rd(32'h0000_005e, 4));
    chk("wbsrc1", 32'h0000_0010, rd(32'h0000_0224, 4));
    chk("wbdst1", 32'h0000_005e, rd(32'h0000_0228, 4));
    chk("wbcnt1", 32'h0000_ffff, rd(32'h0000_022c, 4));
    chk1("irq1", 1'b1, irqSeen[1]);
    chk1("dis1", 1'b0, actDisable[1]);
    $display("zero length test done");
    lat <= 2'h0;
    act(2, 1'b1);
    chk1("irq2", 1'b0, irqSeen[2]);
    act(2, 1'b1);
    chk("dst2", 32'h cafe_beef, rd(32'h0000_00c0, 4));
    chk("wbsrc2", 32'h0000_0084, rd(32'h0000_0244, 4));
    chk("wbdst2", 32'h0000_00c0, rd(32'h0000_0248, 4));
    chk("wbcnt2", 32'h0000_0002, rd(32'h0000_024c, 2));
    chk1("irq2b", 1'b1, irqSeen[2]);
    chk1("dis2", 1'b0, actDisable[2]);
    $display("repeat mode test done");
    act(3, 1'b1);
    chk("dst3a", 32'h5555_0001, rd(32'h0000_00e0, 4));
    chk("dst3b", 32'h5555_0002, rd(32'h0000_00e4, 4));
    chk("wbsrc3", 32'h0000_00a8, rd(32'h0000_0264, 4));
    chk("wbdst3", 32'h0000_00e0, rd(32'h0000_0268, 4));
    chk("wbblk3", 32'h0000_0000, rd(32'h0000_026e, 2));
    chk1("irq3", 1'b1, irqSeen[3]);
    chk1("dis3", 1'b1, actDisable[3]);
    $display("block mode test done");
    lat <= 2'h1;
    act(4, 1'b1);
    chk("dst4a", 32'h1111_2222, rd(32'h0000_00f0, 4));
    chk("dst4b", 32'h3333_4444, rd(32'h0000_00f4, 4));
    chk("wbcnt4a", 32'h0000_0000, rd(32'h0000_028c, 4));
    chk("wbcnt4b", 32'h0000_0000, rd(32'h0000_029c, 4));
    chk1("irq4", 1'b1, irqSeen[4]);
    chk1("busy", 1'b0, busy);
    $display("chain test done");
    print_verdict();
  end
endmodule : vdtc_top_tb
`default_nettype wire
